// File: common/phmd_defines.vh
// constants shared by the phase-matched divider design files
// assumes all input clocks are slow, synchronous levels sampled by the 100 MHz core clock
//
// How it works
// - primary input yields x1, /2, /4, /8 outputs
// - primary delayed output copies primary, same rate
// - aux inputs only delayed, same delay, never divided
// - aux-to-primary skew kept through equal paths
// - divided rising edges match primary delayed rising
// - divided outputs fifty percent duty, any input
// - undivided outputs keep their input duty cycle
// - reset forces every clock output low at once
// - undivided outputs start one cycle after release
// - gate off: divided start on first primary edge once undivided run
// - gate on: divided wait strobe, then primary edge
// - select picks reset-sync clock, primary by default
// - strobe never touches undivided outputs
// - strobe ignored while reset is asserted
// - strobe rising edge only, once per reset
`ifndef PHMD_DEFINES_VH
`define PHMD_DEFINES_VH

// ---------------------------------------------------------------------
// sampled input vector layout
// ---------------------------------------------------------------------
`define PHMD_SMP_W        5
`define PHMD_IDX_PRIMARY  0
`define PHMD_IDX_AUX_B    1
`define PHMD_IDX_AUX_C    2
`define PHMD_IDX_AUX_D    3
`define PHMD_IDX_STROBE   4
`define PHMD_CLK_N        4
`define PHMD_SMP_RST      5'h00

// ---------------------------------------------------------------------
// reset synchronising clock selection codes
// ---------------------------------------------------------------------
`define PHMD_SEL_W        2
`define PHMD_SEL_PRIMARY  2'h0
`define PHMD_SEL_AUX_B    2'h1
`define PHMD_SEL_AUX_C    2'h2
`define PHMD_SEL_AUX_D    2'h3

// ---------------------------------------------------------------------
// divider counter
// ---------------------------------------------------------------------
`define PHMD_DIV_N        3
`define PHMD_CNT_RST      3'h0
`define PHMD_CNT_ONE      3'h1
`define PHMD_DIV_OUT_RST  3'h0
`define PHMD_DLY_OUT_RST  4'h0

`endif

// File: hw/phmd_edge_sampler.v
// registers the clock and strobe inputs and finds their rising edges
// assumes the inputs are already synchronous to the core clock
`include "phmd_defines.vh"

module phmd_edge_sampler
(
    input  wire                   i_clk,
    input  wire                   i_rst,
    input  wire [`PHMD_SMP_W-1:0] i_level,
    output wire [`PHMD_SMP_W-1:0] o_level,
    output wire [`PHMD_SMP_W-1:0] o_rise
);

    reg [`PHMD_SMP_W-1:0] level_reg;
    reg [`PHMD_SMP_W-1:0] prev_reg;

    // ---------------------------------------------------------------------
    // one common sampling stage keeps every path the same length
    // ---------------------------------------------------------------------
    always @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            level_reg <= `PHMD_SMP_RST;
            prev_reg  <= `PHMD_SMP_RST;
        end
        else
        begin
            level_reg <= i_level;
            prev_reg  <= level_reg;
        end
    end

    assign o_level = level_reg;
    assign o_rise  = level_reg & ~prev_reg;

endmodule // phmd_edge_sampler

// File: hw/phmd_top.v
// phase-matched clock divider: delayed copies of four clocks and /2 /4 /8 of the primary
// assumes clock inputs are slow levels synchronous to I_CORE_CLK, sampled, not used as clocks
`include "phmd_defines.vh"

module phmd_top
(
    input  wire                  I_CORE_CLK,
    input  wire                  I_RST,
    input  wire                  I_PRIMARY_CLOCK_IN,
    input  wire                  I_AUX_CLOCK_IN_B,
    input  wire                  I_AUX_CLOCK_IN_C,
    input  wire                  I_AUX_CLOCK_IN_D,
    input  wire [`PHMD_SEL_W-1:0] I_RESET_SYNC_CLOCK_SELECT,
    input  wire                  I_RELEASE_GATE_ENABLE,
    input  wire                  I_RELEASE_STROBE,
    output wire                  O_PRIMARY_DELAYED_OUT,
    output wire                  O_HALF_RATE_OUT,
    output wire                  O_QUARTER_RATE_OUT,
    output wire                  O_EIGHTH_RATE_OUT,
    output wire                  O_AUX_DELAYED_OUT_B,
    output wire                  O_AUX_DELAYED_OUT_C,
    output wire                  O_AUX_DELAYED_OUT_D
);

    // ---------------------------------------------------------------------
    // declarations
    // ---------------------------------------------------------------------
    wire [`PHMD_SMP_W-1:0]  in_level;
    wire [`PHMD_SMP_W-1:0]  smp_level;
    wire [`PHMD_SMP_W-1:0]  smp_rise;
    wire                    sel_rise;
    wire                    primary_rise;
    wire                    strobe_rise;

    reg                     rst_seen_reg;
    reg                     rst_seen_next;
    reg                     run_reg;
    reg                     run_next;
    reg                     rel_seen_reg;
    reg                     rel_seen_next;
    reg                     div_run_reg;
    reg                     div_run_next;
    reg                     div_go;
    reg [`PHMD_DIV_N-1:0]   cnt_reg;
    reg [`PHMD_DIV_N-1:0]   cnt_next;

    reg [`PHMD_CLK_N-1:0]   dly_out_reg;
    wire [`PHMD_CLK_N-1:0]  dly_out_next;
    reg [`PHMD_DIV_N-1:0]   div_out_reg;
    wire [`PHMD_DIV_N-1:0]  div_out_next;

    // ---------------------------------------------------------------------
    // input sampling
    // ---------------------------------------------------------------------
    assign in_level[`PHMD_IDX_PRIMARY] = I_PRIMARY_CLOCK_IN;
    assign in_level[`PHMD_IDX_AUX_B]   = I_AUX_CLOCK_IN_B;
    assign in_level[`PHMD_IDX_AUX_C]   = I_AUX_CLOCK_IN_C;
    assign in_level[`PHMD_IDX_AUX_D]   = I_AUX_CLOCK_IN_D;
    // strobe is a plain level on the primary timing, no synchroniser needed
    assign in_level[`PHMD_IDX_STROBE]  = I_RELEASE_STROBE;

    phmd_edge_sampler u_sampler
    (
        .i_clk   (I_CORE_CLK),
        .i_rst   (I_RST),
        .i_level (in_level),
        .o_level (smp_level),
        .o_rise  (smp_rise)
    );

    // all four select codes are legal; code zero is the primary clock
    assign sel_rise     = smp_rise[I_RESET_SYNC_CLOCK_SELECT];
    assign primary_rise = smp_rise[`PHMD_IDX_PRIMARY];
    assign strobe_rise  = smp_rise[`PHMD_IDX_STROBE];

    // ---------------------------------------------------------------------
    // reset release and start control
    // ---------------------------------------------------------------------
    always @*
    begin
        rst_seen_next = rst_seen_reg;
        run_next      = run_reg;
        rel_seen_next = rel_seen_reg;
        div_go        = 1'b0;
        div_run_next  = div_run_reg;

        // first selected edge registers the release, the next one starts
        if (sel_rise && !rst_seen_reg)
        begin
            rst_seen_next = 1'b1;
        end
        if (sel_rise && rst_seen_reg)
        begin
            run_next = 1'b1;
        end

        // only the first accepted strobe edge counts until the next reset
        if (I_RELEASE_GATE_ENABLE && strobe_rise && !rel_seen_reg)
        begin
            rel_seen_next = 1'b1;
        end

        // divided outputs wait for the undivided ones and, if gated, the strobe
        if (!div_run_reg && run_next && primary_rise)
        begin
            if (!I_RELEASE_GATE_ENABLE)
            begin
                div_go = 1'b1;
            end
            else if (rel_seen_reg)
            begin
                div_go = 1'b1;
            end
            else
            begin
                div_go = 1'b0;
            end
        end
        if (div_go)
        begin
            div_run_next = 1'b1;
        end
    end

    // async clear also keeps the strobe latch empty during reset
    always @(posedge I_CORE_CLK or posedge I_RST)
    begin
        if (I_RST)
        begin
            rst_seen_reg <= 1'b0;
            run_reg      <= 1'b0;
            rel_seen_reg <= 1'b0;
            div_run_reg  <= 1'b0;
        end
        else
        begin
            rst_seen_reg <= rst_seen_next;
            run_reg      <= run_next;
            rel_seen_reg <= rel_seen_next;
            div_run_reg  <= div_run_next;
        end
    end

    // ---------------------------------------------------------------------
    // divider counter
    // ---------------------------------------------------------------------
    // counts only on primary rising edges, so high and low last whole periods
    always @*
    begin
        cnt_next = cnt_reg;
        if (primary_rise && div_run_next)
        begin
            cnt_next = cnt_reg + `PHMD_CNT_ONE;
        end
    end

    always @(posedge I_CORE_CLK or posedge I_RST)
    begin
        if (I_RST)
        begin
            cnt_reg <= `PHMD_CNT_RST;
        end
        else
        begin
            cnt_reg <= cnt_next;
        end
    end

    // ---------------------------------------------------------------------
    // divided outputs
    // ---------------------------------------------------------------------
    // bit n of the inverted count is high for 2^n periods, low for 2^n periods;
    // from the common zero state every bit rises on the same primary edge
    genvar d;
    generate
        for (d = 0; d < `PHMD_DIV_N; d = d + 1)
        begin : g_div
            assign div_out_next[d] = (primary_rise && div_run_next) ? ~cnt_reg[d]
                                                                     : div_out_reg[d];
        end
    endgenerate

    always @(posedge I_CORE_CLK or posedge I_RST)
    begin
        if (I_RST)
        begin
            div_out_reg <= `PHMD_DIV_OUT_RST;
        end
        else
        begin
            div_out_reg <= div_out_next;
        end
    end

    // ---------------------------------------------------------------------
    // undivided delayed outputs
    // ---------------------------------------------------------------------
    // every clock goes through the same sampler and output stage, so the
    // relative skew of the inputs is kept to the core-clock cycle; the strobe
    // path has no way in here
    genvar c;
    generate
        for (c = 0; c < `PHMD_CLK_N; c = c + 1)
        begin : g_dly
            assign dly_out_next[c] = run_next & smp_level[c];
        end
    endgenerate

    always @(posedge I_CORE_CLK or posedge I_RST)
    begin
        if (I_RST)
        begin
            dly_out_reg <= `PHMD_DLY_OUT_RST;
        end
        else
        begin
            dly_out_reg <= dly_out_next;
        end
    end

    // ---------------------------------------------------------------------
    // output ports
    // ---------------------------------------------------------------------
    assign O_PRIMARY_DELAYED_OUT = dly_out_reg[`PHMD_IDX_PRIMARY];
    assign O_AUX_DELAYED_OUT_B   = dly_out_reg[`PHMD_IDX_AUX_B];
    assign O_AUX_DELAYED_OUT_C   = dly_out_reg[`PHMD_IDX_AUX_C];
    assign O_AUX_DELAYED_OUT_D   = dly_out_reg[`PHMD_IDX_AUX_D];
    assign O_HALF_RATE_OUT       = div_out_reg[0];
    assign O_QUARTER_RATE_OUT    = div_out_reg[1];
    assign O_EIGHTH_RATE_OUT     = div_out_reg[2];

endmodule // phmd_top

// File: tb/phmd_clk_src.sv
// upstream sources: four clocks of eight core cycles, a quarter period apart
// assumes i_hi stays within 2 to 6; a new high time applies from the next period on
module phmd_clk_src
(
    input  wire logic       i_clk,
    input  wire logic       i_en,
    input  wire logic [2:0] i_hi,
    output wire logic [3:0] o_lvl
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] ph_reg  = 3'h0;
    logic [3:0] lvl_reg = 4'h0;
    logic [2:0] hi_reg [4] = '{default: 3'h4};
    assign o_lvl = lvl_reg;
    // stands low while disabled, like a stopped source;
    // each clock takes a new high time only in its last, always-low phase,
    // so a duty change never adds a second rising edge inside one period
    always @(posedge i_clk)
    begin
        ph_reg <= i_en ? ph_reg + 3'h1 : 3'h0;
        for (int k = 0; k < 4; k++)
        begin
            if (3'(ph_reg - 2 * k) == 3'h7)
                hi_reg[k] <= i_hi;
            lvl_reg[k] <= i_en && 3'(ph_reg - 2 * k) < hi_reg[k];
        end
    end
endmodule // phmd_clk_src

// File: tb/phmd_properties.sv
// port-level checks of the divider top
// assumes inputs change just after I_CORE_CLK rising edges
module phmd_properties
(
    input wire logic       I_CORE_CLK,
    input wire logic       I_RST,
    input wire logic       I_PRIMARY_CLOCK_IN,
    input wire logic       I_AUX_CLOCK_IN_B,
    input wire logic       I_AUX_CLOCK_IN_C,
    input wire logic       I_AUX_CLOCK_IN_D,
    input wire logic [1:0] I_RESET_SYNC_CLOCK_SELECT,
    input wire logic       I_RELEASE_GATE_ENABLE,
    input wire logic       I_RELEASE_STROBE,
    input wire logic       O_PRIMARY_DELAYED_OUT,
    input wire logic       O_HALF_RATE_OUT,
    input wire logic       O_QUARTER_RATE_OUT,
    input wire logic       O_EIGHTH_RATE_OUT,
    input wire logic       O_AUX_DELAYED_OUT_B,
    input wire logic       O_AUX_DELAYED_OUT_C,
    input wire logic       O_AUX_DELAYED_OUT_D
);
    timeunit 1ns;
    timeprecision 1ps;
    wire [3:0] ins = {I_AUX_CLOCK_IN_D, I_AUX_CLOCK_IN_C, I_AUX_CLOCK_IN_B, I_PRIMARY_CLOCK_IN};
    wire [3:0] und = {O_AUX_DELAYED_OUT_D, O_AUX_DELAYED_OUT_C, O_AUX_DELAYED_OUT_B, O_PRIMARY_DELAYED_OUT};
    wire [2:0] dv  = {O_EIGHTH_RATE_OUT, O_QUARTER_RATE_OUT, O_HALF_RATE_OUT};
    logic [1:0] cnt_reg;
    logic       prv_reg, run_reg, div_reg, stb_reg;
    // rises of the selected clock are counted here, so start timing is judged apart from the design
    always_ff @(posedge I_CORE_CLK or posedge I_RST)
    begin
        if (I_RST)
            {cnt_reg, prv_reg, run_reg, div_reg, stb_reg} <= 6'h00;
        else
        begin
            prv_reg <= ins[I_RESET_SYNC_CLOCK_SELECT];
            if (ins[I_RESET_SYNC_CLOCK_SELECT] && !prv_reg && cnt_reg != 2'h2)
                cnt_reg <= cnt_reg + 2'h1;
            run_reg <= run_reg | (|und);
            div_reg <= div_reg | O_HALF_RATE_OUT;
            stb_reg <= stb_reg | I_RELEASE_STROBE;
        end
    end
    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (I_RST);
    sequence s_arm; cnt_reg == 2'h1 ##1 cnt_reg == 2'h2; endsequence
    property p_rst; disable iff (1'b0) I_RST |-> {und, dv} == 7'h00; endproperty
    a_rst: assert property (p_rst) else $error("output high in reset");
    property p_follow; run_reg |-> und == $past(ins, 2); endproperty
    a_follow: assert property (p_follow) else $error("copy differs");
    property p_early; cnt_reg != 2'h2 |-> {und, dv} == 7'h00; endproperty
    a_early: assert property (p_early) else $error("early start");
    property p_start; s_arm |=> und == $past(ins, 2); endproperty
    a_start: assert property (p_start) else $error("late start");
    property p_edge; $changed(dv) |-> $rose(O_PRIMARY_DELAYED_OUT); endproperty
    a_edge: assert property (p_edge) else $error("divided off edge");
    property p_half; div_reg && $rose(O_PRIMARY_DELAYED_OUT) |-> $changed(O_HALF_RATE_OUT); endproperty
    a_half: assert property (p_half) else $error("half stuck");
    property p_chain;
        div_reg |-> $changed(O_QUARTER_RATE_OUT) == $rose(O_HALF_RATE_OUT)
            && $changed(O_EIGHTH_RATE_OUT) == $rose(O_QUARTER_RATE_OUT);
    endproperty
    a_chain: assert property (p_chain) else $error("bad ratio");
    property p_align; $rose(O_EIGHTH_RATE_OUT) |-> $rose(O_HALF_RATE_OUT) && $rose(O_QUARTER_RATE_OUT); endproperty
    a_align: assert property (p_align) else $error("unaligned");
    property p_hold; I_RELEASE_GATE_ENABLE && !stb_reg |-> !O_HALF_RATE_OUT; endproperty
    a_hold: assert property (p_hold) else $error("gate leak");
endmodule // phmd_properties

bind phmd_top phmd_properties chk_u
(
    .I_CORE_CLK(I_CORE_CLK), .I_RST(I_RST), .I_PRIMARY_CLOCK_IN(I_PRIMARY_CLOCK_IN),
    .I_AUX_CLOCK_IN_B(I_AUX_CLOCK_IN_B), .I_AUX_CLOCK_IN_C(I_AUX_CLOCK_IN_C), .I_AUX_CLOCK_IN_D(I_AUX_CLOCK_IN_D),
    .I_RESET_SYNC_CLOCK_SELECT(I_RESET_SYNC_CLOCK_SELECT), .I_RELEASE_GATE_ENABLE(I_RELEASE_GATE_ENABLE),
    .I_RELEASE_STROBE(I_RELEASE_STROBE), .O_PRIMARY_DELAYED_OUT(O_PRIMARY_DELAYED_OUT),
    .O_HALF_RATE_OUT(O_HALF_RATE_OUT), .O_QUARTER_RATE_OUT(O_QUARTER_RATE_OUT), .O_EIGHTH_RATE_OUT(O_EIGHTH_RATE_OUT),
    .O_AUX_DELAYED_OUT_B(O_AUX_DELAYED_OUT_B), .O_AUX_DELAYED_OUT_C(O_AUX_DELAYED_OUT_C),
    .O_AUX_DELAYED_OUT_D(O_AUX_DELAYED_OUT_D)
);

// File: tb/tb.sv
// self-checking bench for phmd_top
// assumes phmd_clk_src and the bound checker are compiled first
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PER = 8;
    localparam int WIN = 8 * PER;
    localparam int N1  = WIN / PER;
    logic        core_clk = 1'b0;
    logic        rst      = 1'b0;
    logic [1:0]  sel      = 2'h0;
    logic        gate     = 1'b0;
    logic        strobe   = 1'b0;
    logic        en       = 1'b0;
    logic [2:0]  hi       = 3'h4;
    logic [31:0] lfsr     = 32'h82019F09;
    logic [55:0] res, exp_w;
    logic [55:0] exp_q[$];
    wire  [3:0]  clks;
    wire  [6:0]  outs;
    event        res_ev;
    int          miscompares = 0;
    int          num_checks  = 0;

    initial forever #5 core_clk = ~core_clk;

    phmd_clk_src src_u (.i_clk(core_clk), .i_en(en), .i_hi(hi), .o_lvl(clks));
    phmd_top dut_u
    (
        .I_CORE_CLK(core_clk), .I_RST(rst), .I_PRIMARY_CLOCK_IN(clks[0]),
        .I_AUX_CLOCK_IN_B(clks[1]), .I_AUX_CLOCK_IN_C(clks[2]), .I_AUX_CLOCK_IN_D(clks[3]),
        .I_RESET_SYNC_CLOCK_SELECT(sel), .I_RELEASE_GATE_ENABLE(gate), .I_RELEASE_STROBE(strobe),
        .O_PRIMARY_DELAYED_OUT(outs[0]), .O_HALF_RATE_OUT(outs[1]), .O_QUARTER_RATE_OUT(outs[2]),
        .O_EIGHTH_RATE_OUT(outs[3]), .O_AUX_DELAYED_OUT_B(outs[4]), .O_AUX_DELAYED_OUT_C(outs[5]),
        .O_AUX_DELAYED_OUT_D(outs[6])
    );

    task automatic complete_run;
        $display("checks=%0d mismatches=%0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    // reset is raised between edges on purpose: outputs must clear without a clock
    task automatic do_reset(input logic [1:0] s, input logic g);
        @(posedge core_clk);
        #2 rst = 1'b1;
        #1 res = {49'h0, outs};
        exp_q.push_back(56'h0);
        -> res_ev;
        @(posedge core_clk);
        en     <= 1'b1;
        sel    <= s;
        gate   <= g;
        strobe <= g;
        @(posedge core_clk);
        strobe <= 1'b0;
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
    endtask

    task automatic wait_run;
        int n;
        n = 0;
        while (outs[0] !== 1'b1)
        begin
            @(posedge core_clk);
            #1 n++;
            if (n > 40)
            begin
                miscompares++;
                complete_run;
            end
        end
        repeat (12) @(posedge core_clk);
    endtask

    task automatic pulse(input int d);
        repeat (d + 1) @(posedge core_clk);
        strobe <= 1'b1;
        @(posedge core_clk);
        strobe <= 1'b0;
    endtask

    // rises per window are phase-free, so the note needs no alignment
    task automatic measure(input logic run_div);
        logic [6:0] prev;
        logic [7:0] cnt [7];
        cnt = '{default: 8'h0};
        @(posedge core_clk);
        lfsr = lfsr_next(lfsr);
        hi <= 3'h2 + 3'(lfsr % 5);
        exp_q.push_back({{3{8'(N1)}}, run_div ? {8'(N1 / 8), 8'(N1 / 4), 8'(N1 / 2)} : 24'h0, 8'(N1)});
        #1 prev = outs;
        repeat (WIN)
        begin
            @(posedge core_clk);
            #1;
            for (int i = 0; i < 7; i++)
                cnt[i] += {7'h0, outs[i] & ~prev[i]};
            prev = outs;
        end
        for (int i = 0; i < 7; i++)
            res[8 * i +: 8] = cnt[i];
        -> res_ev;
    endtask

    always @(res_ev)
    begin
        exp_w = exp_q.pop_front();
        num_checks++;
        if (res !== exp_w)
        begin
            $display("[FAIL] t=%0t exp=%h got=%h", $time, exp_w, res);
            miscompares++;
        end
    end

    initial
    begin
        // a real rising edge on reset clears the design before the first clock edge samples it
        #1 rst = 1'b1;
        for (int s = 0; s < 4; s++)
        begin
            do_reset(2'(s), 1'b0);
            wait_run;
            measure(1'b1);
        end
        do_reset(2'h1, 1'b1);
        wait_run;
        measure(1'b0);
        pulse(0);
        repeat (20) @(posedge core_clk);
        fork
            measure(1'b1);
            pulse(20);
        join
        complete_run;
    end
endmodule // tb
